// ==== bench/cpl_link_partner_model.sv ====
// Remote link partner PHY model on the far side of the twisted pair
`timescale 1ns/100ps
module cpl_link_partner_model
	import cpl_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       awake,
	input  wire logic       glitch,
	input  wire logic       flp_send,
	input  wire logic       flp_pair_b,
	output logic            energy_raw,
	output logic            link_ok,
	output logic [7:0]      burst_cnt,
	output logic            pair_err
);
	logic       sig_q;
	logic [4:0] up_q;
	logic       prev_q;

	// ----
	// Partner answers a wake burst with steady energy, link follows
	// ----
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sig_q     <= 1'b0;
			up_q      <= 5'h00;
			burst_cnt <= 8'h00;
			pair_err  <= 1'b0;
			prev_q    <= 1'b1;
		end
		else
		begin
			sig_q <= awake & (sig_q | flp_send);
			up_q  <= (sig_q & awake) ? ((up_q == 5'h14) ? up_q : up_q + 5'h01) : 5'h00;
			if (flp_send)
			begin
				burst_cnt <= burst_cnt + 8'h01;
				prev_q    <= flp_pair_b;
				if (flp_pair_b == prev_q)
					pair_err <= 1'b1;
			end
		end
	end

	// Powered-down partner puts no energy on the line
	assign energy_raw = sig_q | glitch;
	assign link_ok    = (up_q == 5'h14);
endmodule : cpl_link_partner_model

// ==== bench/cpl_power_manager_tb.sv ====
// Self-checking testbench for the copper link power manager
`timescale 1ns/100ps
module cpl_power_manager_tb
	import cpl_pkg::*;
;
	localparam int MS    = 8;
	localparam int LIMIT = 90000;
	logic        ref_clk, rst, ce, psel, penable, pwrite;
	logic [7:0]  paddr, burst_cnt, b0;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, se, energy_raw, link_ok;
	logic        low_power, pwrdn, flp_send, flp_pair_b;
	logic        awake, glitch, pair_err;
	int          err_total, compares, cyc, t0;

	cpl_power_manager #(.MS_CYCLES(MS), .DEB_LEN(8)) i_dut (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .energy_raw(energy_raw),
		.link_ok(link_ok), .low_power(low_power), .pwrdn(pwrdn),
		.flp_send(flp_send), .flp_pair_b(flp_pair_b));

	cpl_link_partner_model i_partner (
		.ref_clk(ref_clk), .rst(rst), .awake(awake), .glitch(glitch),
		.flp_send(flp_send), .flp_pair_b(flp_pair_b), .energy_raw(energy_raw),
		.link_ok(link_ok), .burst_cnt(burst_cnt), .pair_err(pair_err));

	// ----
	// Shared tasks
	// ----
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Bounded wait for the low power indication to reach a level
	task automatic wait_lp(input logic v, input int lim);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (low_power !== v && n < lim)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("low_power", {31'h0, low_power}, {31'h0, v});
	endtask : wait_lp

	task automatic finish_test();
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// Clock and cycle counter with hang guard
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			err_total++;
			finish_test();
		end
	end

	// ----
	// Main sequence
	// ----
	initial
	begin
		{ref_clk, psel, penable, pwrite, awake, glitch} = 6'h00;
		{rst, ce} = 2'h3;
		{paddr, pwdata, err_total, compares, cyc} = '0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, CPL_OFS_BASIC, 32'h0);
		chk("basic", rd, CPL_RST_BASIC);
		apb(1'b0, CPL_OFS_AUXCTL, 32'h0);
		chk("auxctl", rd, CPL_RST_AUXCTL);
		apb(1'b0, CPL_OFS_TIMERS, 32'h0);
		chk("timers", rd, 32'h0000_2000);
		apb(1'b0, CPL_OFS_STATUS, 32'h0);
		chk("status", rd, 32'h0000_0002);
		apb(1'b1, 8'h10, 32'hffff_ffff);
		chk("unmapped err", {31'h0, se}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, CPL_OFS_BASIC, 32'h0000_1800);
		@(negedge ref_clk);
		chk("pwrdn on", {31'h0, pwrdn}, 32'h1);
		chk("low_power off", {31'h0, low_power}, 32'h0);
		apb(1'b1, CPL_OFS_BASIC, 32'h0000_1000);
		@(negedge ref_clk);
		chk("pwrdn off", {31'h0, pwrdn}, 32'h0);
		apb(1'b1, CPL_OFS_TIMERS, 32'h0);
		apb(1'b1, CPL_OFS_AUXCTL, 32'h0000_0044);
		wait_lp(1'b1, 1000 * MS + 100);
		// Two full sleep and wake cycles with no partner energy
		for (int i = 0; i < 2; i++)
		begin
			wait_lp(1'b0, 2100 * MS);
			t0 = cyc;
			b0 = burst_cnt;
			apb(1'b0, CPL_OFS_STATUS, 32'h0);
			chk("wake state", {30'h0, rd[1:0]}, 32'h1);
			wait_lp(1'b1, 110 * MS);
			chk("wake time", 32'((cyc - t0) inside {[99 * MS - 2 : 100 * MS + 2]}), 32'h1);
			chk("bursts", {24'h0, burst_cnt - b0}, 32'h3);
			chk("pair", {31'h0, pair_err}, 32'h0);
			t0 = cyc;
			apb(1'b0, CPL_OFS_STATUS, 32'h0);
			chk("low state", {30'h0, rd[1:0]}, 32'h0);
			wait_lp(1'b0, 1100 * MS);
			chk("sleep time", 32'((cyc - t0) inside {[919 * MS - 2 : 1060 * MS + 2]}), 32'h1);
		end
		wait_lp(1'b1, 110 * MS);
		// Single-cycle noise on the energy line
		repeat (50) @(posedge ref_clk);
		glitch <= 1'b1;
		@(posedge ref_clk);
		glitch <= 1'b0;
		repeat (40) @(posedge ref_clk);
		apb(1'b0, CPL_OFS_STATUS, 32'h0);
		chk("glitch", {30'h0, rd[1:0]}, 32'h0);
		// Partner answers the next burst
		@(posedge ref_clk);
		awake <= 1'b1;
		wait_lp(1'b0, 1100 * MS);
		repeat (40) @(posedge ref_clk);
		apb(1'b0, CPL_OFS_STATUS, 32'h0);
		chk("link up", {28'h0, rd[3:0]}, 32'h0000_000e);
		// Partner powers down: time-out select 1
		@(posedge ref_clk);
		awake <= 1'b0;
		t0 = cyc;
		wait_lp(1'b1, 1010 * MS);
		chk("timeout", 32'((cyc - t0) inside {[999 * MS : 1000 * MS + 4]}), 32'h1);
		// Back to normal, then autoneg off and a link drop
		@(posedge ref_clk);
		awake <= 1'b1;
		wait_lp(1'b0, 1100 * MS);
		repeat (40) @(posedge ref_clk);
		apb(1'b1, CPL_OFS_BASIC, 32'h0);
		@(posedge ref_clk);
		awake <= 1'b0;
		repeat (1010 * MS) @(posedge ref_clk);
		apb(1'b0, CPL_OFS_STATUS, 32'h0);
		chk("stay normal", {30'h0, rd[1:0]}, 32'h2);
		chk("pwrdn kept", {31'h0, pwrdn}, 32'h0);
		finish_test();
	end
endmodule : cpl_power_manager_tb

// ==== verilog/cpl_energy_filter.sv ====
// Synchroniser and debouncer for the media signal-energy indication
`timescale 1ns/100ps
module cpl_energy_filter
	import cpl_pkg::*;
#(
	parameter int DEB_LEN = 8
)(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic energy_raw,
	output logic      energy_ok
);
	localparam int CW = $clog2(DEB_LEN + 1);

	logic          sync1_q, sync1_d;
	logic          sync2_q, sync2_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          stab_q, stab_d;

	// Next values: count consecutive samples that differ from the stable level
	always_comb
	begin
		sync1_d = energy_raw;
		sync2_d = sync1_q;
		cnt_d   = '0;
		stab_d  = stab_q;
		if (sync2_q != stab_q)
		begin
			cnt_d = cnt_q + CW'(1);
			if (cnt_q == CW'(DEB_LEN - 1))
			begin
				stab_d = sync2_q;
				cnt_d  = '0;
			end
		end
	end

	// Registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cnt_q   <= '0;
			stab_q  <= 1'b0;
		end
		else if (ce)
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			cnt_q   <= cnt_d;
			stab_q  <= stab_d;
		end
	end

	assign energy_ok = stab_q;

endmodule : cpl_energy_filter

// ==== verilog/cpl_pkg.sv ====
// Constants, field layouts and types for the copper link power manager
package cpl_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  CPL_OFS_BASIC  = 8'h00;  // Basic control
	localparam logic [7:0]  CPL_OFS_AUXCTL = 8'h04;  // Auto power mode control
	localparam logic [7:0]  CPL_OFS_TIMERS = 8'h08;  // Sleep and wake-up timers
	localparam logic [7:0]  CPL_OFS_STATUS = 8'h0c;  // Live state, read only

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CPL_BIT_PWRDN     = 11;  // Basic: standard power-down
	localparam int CPL_BIT_ANEG      = 12;  // Basic: autonegotiation enable
	localparam int CPL_BIT_AUTO_EN   = 6;   // Auxctl: auto power mode enable
	localparam int CPL_BIT_LTO_HI    = 7;   // Auxctl: link time-out select high
	localparam int CPL_BIT_LTO_LO    = 2;   // Auxctl: link time-out select low
	localparam int CPL_SLEEP_HI      = 14;  // Timers: sleep field
	localparam int CPL_SLEEP_LO      = 13;
	localparam int CPL_WAKE_HI       = 12;  // Timers: wake-up field
	localparam int CPL_WAKE_LO       = 11;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CPL_RST_BASIC  = 32'h0000_1000;  // Autoneg on
	localparam logic [31:0] CPL_RST_AUXCTL = 32'h0000_0000;
	localparam logic [31:0] CPL_RST_TIMERS = 32'h0000_2000;  // Sleep code 1: two seconds

	// ----------------------------------------------------------------
	// Timing, in milliseconds
	// ----------------------------------------------------------------
	localparam logic [15:0] CPL_SLEEP_STEP_MS = 16'h03e8;  // 1000 ms per sleep code step
	localparam logic [15:0] CPL_RAND_NEG_MS   = 16'h0050;  // 80 ms below nominal
	localparam logic [15:0] CPL_RAND_STEP_MS  = 16'h000a;  // 10 ms per random step
	localparam logic [3:0]  CPL_RAND_STEPS    = 4'he;      // 0..14 steps: -80..+60 ms
	localparam logic [15:0] CPL_WAKE_STEP_MS  = 16'h0064;  // 100 ms per wake code step
	localparam logic [15:0] CPL_LTO_STEP_MS   = 16'h01f4;  // 500 ms per time-out code step
	localparam logic [15:0] CPL_FLP_GAP_MS    = 16'h0010;  // 16 ms between bursts
	localparam logic [1:0]  CPL_FLP_MAX       = 2'h3;      // Bursts per wake-up visit
	localparam int          CPL_CLK_MHZ       = 200;
	localparam int          CPL_MS_CYCLES     = CPL_CLK_MHZ * 1000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CPL_ST_LOW  = 2'b00,
		CPL_ST_WAKE = 2'b01,
		CPL_ST_NORM = 2'b10
	} cpl_state_t;

	typedef struct packed {
		logic       auto_en;
		logic       aneg_en;
		logic       pwrdn;
		logic [1:0] sleep_sel;
		logic [1:0] wake_sel;
		logic [1:0] lto_sel;
	} cpl_ctrl_t;

endpackage : cpl_pkg

// ==== verilog/cpl_power_manager.sv ====
// Per-port automatic link power manager with APB register slave
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
// Function
// - Auto power mode turns on whenever software sets the enable bit.
// - Standard power-down bit is a separate control, unaffected by auto mode.
// - Auto mode uses exactly three states: low power, wake-up, normal.
// - Without energy, low power and wake-up alternate; default period two seconds.
// - Detected energy in low power or wake-up moves to normal.
// - With autoneg on, link loss returns to low power after time-out.
// - After reset the state machine starts in low power.
// - Autoneg off, forced speed: cycle until energy, then stay normal.
// - Autoneg disabled in normal: link drop keeps port in normal.
// - Low power powers down major blocks; management and energy monitor stay.
// - Energy from any autoneg partner or waking port counts as wake energy.
// - Sleep interval comes from the two-bit sleep timer field.
// - Each sleep interval gets a random offset from -80 to +60 ms.
// - Wake-up sends up to three bursts alternating pairs A and B.
// - After wake-up energy is sent, return to low power; management stays.
// - Link status time-out chosen by two control bits.
module cpl_power_manager
	import cpl_pkg::*;
#(
	parameter int MS_CYCLES = CPL_MS_CYCLES,
	parameter int DEB_LEN   = 8
)(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        energy_raw,
	input  wire logic        link_ok,
	output logic             low_power,
	output logic             pwrdn,
	output logic             flp_send,
	output logic             flp_pair_b
);
	localparam int PW = $clog2(MS_CYCLES);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0] basic_q, basic_d;
	logic [31:0] auxctl_q, auxctl_d;
	logic [31:0] timers_q, timers_d;
	logic [31:0] rdata_q, rdata_d;
	logic        err_q, err_d;
	cpl_ctrl_t   ctrl;
	cpl_state_t  state_q, state_d;
	logic        energy_ok;

	// Known offsets decode
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == CPL_OFS_BASIC) || (a == CPL_OFS_AUXCTL) ||
			(a == CPL_OFS_TIMERS) || (a == CPL_OFS_STATUS);
	endfunction : addr_hit

	// Field view of the control registers
	always_comb
	begin
		ctrl.auto_en   = auxctl_q[CPL_BIT_AUTO_EN];
		ctrl.aneg_en   = basic_q[CPL_BIT_ANEG];
		ctrl.pwrdn     = basic_q[CPL_BIT_PWRDN];
		ctrl.sleep_sel = timers_q[CPL_SLEEP_HI:CPL_SLEEP_LO];
		ctrl.wake_sel  = timers_q[CPL_WAKE_HI:CPL_WAKE_LO];
		ctrl.lto_sel   = {auxctl_q[CPL_BIT_LTO_HI], auxctl_q[CPL_BIT_LTO_LO]};
	end

	// Writes land in the access phase; read data captured in the setup phase
	always_comb
	begin
		basic_d  = basic_q;
		auxctl_d = auxctl_q;
		timers_d = timers_q;
		rdata_d  = rdata_q;
		err_d    = err_q;
		if (psel && !penable)
		begin
			err_d = !addr_hit(paddr);
			case (paddr)
				CPL_OFS_BASIC:  rdata_d = basic_q;
				CPL_OFS_AUXCTL: rdata_d = auxctl_q;
				CPL_OFS_TIMERS: rdata_d = timers_q;
				CPL_OFS_STATUS: rdata_d = {28'h000_0000, energy_ok, link_ok, state_q};
				default:        rdata_d = 32'h0000_0000;
			endcase
		end
		if (psel && penable && pwrite)
		begin
			case (paddr)
				CPL_OFS_BASIC:  basic_d  = pwdata;
				CPL_OFS_AUXCTL: auxctl_d = pwdata;
				CPL_OFS_TIMERS: timers_d = pwdata;
				default:        basic_d  = basic_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			basic_q  <= CPL_RST_BASIC;
			auxctl_q <= CPL_RST_AUXCTL;
			timers_q <= CPL_RST_TIMERS;
			rdata_q  <= 32'h0000_0000;
			err_q    <= 1'b0;
		end
		else if (ce)
		begin
			basic_q  <= basic_d;
			auxctl_q <= auxctl_d;
			timers_q <= timers_d;
			rdata_q  <= rdata_d;
			err_q    <= err_d;
		end
	end

	// Zero-wait slave; management works in every power state
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = psel && penable && err_q;

	// ----------------------------------------------------------------
	// Energy filter
	// ----------------------------------------------------------------
	cpl_energy_filter #(
		.DEB_LEN    (DEB_LEN)
	) u_filter (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.ce         (ce),
		.energy_raw (energy_raw),
		.energy_ok  (energy_ok)
	);

	// ----------------------------------------------------------------
	// Millisecond tick and random source
	// ----------------------------------------------------------------
	logic [PW-1:0] pre_q, pre_d;
	logic          ms_tick;
	logic [7:0]    lfsr_q, lfsr_d;
	logic [3:0]    rnd;

	// Prescaler and free-running LFSR
	always_comb
	begin
		ms_tick = (pre_q == PW'(MS_CYCLES - 1));
		pre_d   = ms_tick ? '0 : pre_q + PW'(1);
		lfsr_d  = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		rnd     = (lfsr_q[3:0] > CPL_RAND_STEPS) ? 4'h0 : lfsr_q[3:0];
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pre_q  <= '0;
			lfsr_q <= 8'h01;
		end
		else if (ce)
		begin
			pre_q  <= pre_d;
			lfsr_q <= lfsr_d;
		end
	end

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	logic [15:0] tmr_q, tmr_d;
	logic [15:0] gap_q, gap_d;
	logic [1:0]  burst_q, burst_d;
	logic        pair_q, pair_d;
	logic        send_q, send_d;
	logic        lto_run_q, lto_run_d;
	logic [15:0] sleep_ms, wake_ms, lto_ms;
	logic        tmr_done;

	// Interval lengths from the timer fields and the auxctl time-out select bits
	always_comb
	begin
		sleep_ms = 16'((16'(ctrl.sleep_sel) + 16'h0001) * CPL_SLEEP_STEP_MS - CPL_RAND_NEG_MS
			+ 16'(rnd) * CPL_RAND_STEP_MS);
		wake_ms  = 16'((16'(ctrl.wake_sel) + 16'h0001) * CPL_WAKE_STEP_MS);
		lto_ms   = 16'((16'(ctrl.lto_sel) + 16'h0001) * CPL_LTO_STEP_MS);
		tmr_done = ms_tick && (tmr_q <= 16'h0001);
	end

	// Next state, timers and burst requests
	always_comb
	begin
		state_d   = state_q;
		tmr_d     = (ms_tick && tmr_q != 16'h0000) ? tmr_q - 16'h0001 : tmr_q;
		gap_d     = (ms_tick && gap_q != 16'h0000) ? gap_q - 16'h0001 : gap_q;
		burst_d   = burst_q;
		pair_d    = pair_q;
		send_d    = 1'b0;
		lto_run_d = lto_run_q;
		if (!ctrl.auto_en)
		begin
			state_d   = CPL_ST_NORM;
			lto_run_d = 1'b0;
		end
		else
		begin
			case (state_q)
				CPL_ST_LOW:
				begin
					if (energy_ok)
						state_d = CPL_ST_NORM;
					else if (tmr_done)
					begin
						state_d = CPL_ST_WAKE;
						tmr_d   = wake_ms;
						gap_d   = 16'h0000;
						burst_d = 2'h0;
					end
				end
				CPL_ST_WAKE:
				begin
					if (energy_ok)
						state_d = CPL_ST_NORM;
					else if (tmr_done)
					begin
						state_d = CPL_ST_LOW;
						tmr_d   = sleep_ms;
					end
					else if (gap_q == 16'h0000 && burst_q < CPL_FLP_MAX)
					begin
						send_d  = 1'b1;
						pair_d  = !pair_q;
						burst_d = burst_q + 2'h1;
						gap_d   = CPL_FLP_GAP_MS;
					end
				end
				CPL_ST_NORM:
				begin
					if (link_ok || !ctrl.aneg_en)
						lto_run_d = 1'b0;
					else if (!lto_run_q)
					begin
						lto_run_d = 1'b1;
						tmr_d     = lto_ms;
					end
					else if (tmr_done)
					begin
						state_d   = CPL_ST_LOW;
						lto_run_d = 1'b0;
						tmr_d     = sleep_ms;
					end
				end
				default:
					state_d = CPL_ST_LOW;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_q   <= CPL_ST_LOW;
			tmr_q     <= CPL_SLEEP_STEP_MS + CPL_SLEEP_STEP_MS;
			gap_q     <= 16'h0000;
			burst_q   <= 2'h0;
			pair_q    <= 1'b1;
			send_q    <= 1'b0;
			lto_run_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q   <= state_d;
			tmr_q     <= tmr_d;
			gap_q     <= gap_d;
			burst_q   <= burst_d;
			pair_q    <= pair_d;
			send_q    <= send_d;
			lto_run_q <= lto_run_d;
		end
	end

	// Outputs
	assign low_power  = ctrl.auto_en && (state_q == CPL_ST_LOW);
	assign pwrdn      = ctrl.pwrdn;
	assign flp_send   = send_q;
	assign flp_pair_b = pair_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_reset_low_state: assert property ($fell(rst) |-> state_q == CPL_ST_LOW)
		else $error("state not low power after reset");
	a_energy_to_norm: assert property (ce && ctrl.auto_en && energy_ok && state_q != CPL_ST_NORM
		|=> state_q == CPL_ST_NORM)
		else $error("energy did not bring normal state");
	a_wake_needs_timer: assert property (state_q == CPL_ST_LOW && ctrl.auto_en
		##1 state_q == CPL_ST_WAKE |-> $past(tmr_done))
		else $error("wake-up entered before sleep timer");
	a_burst_in_wake: assert property (flp_send |-> $past(state_q) == CPL_ST_WAKE)
		else $error("burst outside wake-up");
	a_burst_alternate: assert property ($past(ce) && flp_send |-> flp_pair_b != $past(flp_pair_b))
		else $error("bursts on same pair");
	a_burst_limit: assert property (ce && burst_q == CPL_FLP_MAX
		|=> !flp_send)
		else $error("more than three bursts");
	a_forced_stays: assert property (ce && ctrl.auto_en && state_q == CPL_ST_NORM && !ctrl.aneg_en
		|=> state_q == CPL_ST_NORM)
		else $error("left normal with autoneg off");
	a_norm_exit_lto: assert property (state_q == CPL_ST_NORM ##1 state_q == CPL_ST_LOW
		|-> $past(lto_run_q) && $past(tmr_done))
		else $error("normal left without time-out");
	a_pwrdn_separate: assert property ((pwrdn == basic_q[CPL_BIT_PWRDN] && $stable(pwrdn))
		|| ($past(psel) && $past(pwrite)))
		else $error("power-down bit disturbed");
	a_sleep_range: assert property (ce && state_q == CPL_ST_WAKE && state_d == CPL_ST_LOW
		|-> sleep_ms >= (16'(ctrl.sleep_sel) + 16'h0001) * CPL_SLEEP_STEP_MS - CPL_RAND_NEG_MS
		&& sleep_ms <= (16'(ctrl.sleep_sel) + 16'h0001) * CPL_SLEEP_STEP_MS + 16'h003c)
		else $error("sleep offset out of range");

	c_wake_visit: cover property (state_q == CPL_ST_LOW ##1 state_q == CPL_ST_WAKE);
	c_three_bursts: cover property (flp_send && burst_q == CPL_FLP_MAX);
	c_link_loss: cover property (state_q == CPL_ST_NORM ##1 state_q == CPL_ST_LOW);

endmodule : cpl_power_manager
